// ===== design/tma_bank.sv
// transmit multi-phy address bank: host registers plus poll response
// assumes host strobes on core_clk; the link clock and address bus are
// foreign and are synchronised here; fifo space flags are on core_clk
`timescale 1ns/1ps
`default_nettype none

module tma_bank (
  input  wire logic        core_clk,              // 100 MHz core clock
  input  wire logic        rstn,                  // sync reset, low
  input  wire logic [11:0] reg_addr,              // register offset
  input  wire logic        reg_wr,                // write strobe
  input  wire logic        reg_rd,                // read strobe
  input  wire logic [7:0]  reg_wdata,             // write data
  output logic      [7:0]  reg_rdata,             // read data
  input  wire logic [3:0]  tx_fifo_space,         // room for a cell
  input  wire logic        tx_interface_clock,    // link clock pin
  input  wire logic [4:0]  tx_phy_address_bus,    // poll address pins
  output logic             tx_cell_available_out, // cell-available level
  output logic             tx_cell_available_oe,  // high while driving
  output logic             multi_phy_mode         // mode bit in use
);

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  tma_pkg::tma_state_s q_r;     // registered state
  tma_pkg::tma_state_s q_nxt;   // next state
  logic                link_edge; // rising edge of link clock
  logic                hit;       // sampled address owned here
  logic [1:0]          hit_chan;  // owning channel

  // pointer values above three select no channel
  function automatic logic ptr_valid(input logic [4:0] p);
    ptr_valid = (p < 5'(tma_pkg::CHAN_NUM));
  endfunction

  // read value of the address register for the current pointer
  function automatic logic [7:0] addr_view(input tma_pkg::tma_state_s s);
    addr_view = tma_pkg::RDATA_IDLE;
    if (ptr_valid(s.select)) begin
      addr_view = {3'h0, s.chan_addr[s.select[1:0]]};
    end
  endfunction

  assign link_edge = q_r.clk_s2 & ~q_r.clk_s3;

  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  tma_addr_match u_match (
    .bus_addr  (q_r.bus_s2),
    .chan_addr (q_r.chan_addr),
    .hit       (hit),
    .chan      (hit_chan)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    // two-stage synchronisers for the pins
    q_nxt.clk_s1 = tx_interface_clock;
    q_nxt.clk_s2 = q_r.clk_s1;
    q_nxt.clk_s3 = q_r.clk_s2;
    q_nxt.bus_s1 = tx_phy_address_bus;
    q_nxt.bus_s2 = q_r.bus_s1;

    // host writes
    if (reg_wr) begin
      unique case (reg_addr)
        tma_pkg::OFS_TX_CTRL0: begin
          q_nxt.ctrl0 = reg_wdata; // RULE_09
        end
        tma_pkg::OFS_TX_SELECT: begin
          q_nxt.select = reg_wdata[4:0]; // RULE_02
        end
        tma_pkg::OFS_TX_ADDR: begin
          // only the pointed channel changes; receive side not here
          if (ptr_valid(q_r.select)) begin // RULE_10 RULE_06
            q_nxt.chan_addr[q_r.select[1:0]] = reg_wdata[4:0]; // RULE_03
          end
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end

    // host reads, answered one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        tma_pkg::OFS_TX_CTRL0:  q_nxt.rdata = q_r.ctrl0;
        tma_pkg::OFS_TX_SELECT: q_nxt.rdata = {3'h0, q_r.select};
        tma_pkg::OFS_TX_ADDR:   q_nxt.rdata = addr_view(q_r);
        default:                q_nxt.rdata = tma_pkg::RDATA_IDLE;
      endcase
    end

    // poll response, updated once per link clock rising edge
    if (link_edge) begin
      if (!q_r.ctrl0[tma_pkg::MULTI_PHY_BIT]) begin
        // single phy: always own the line, channel 0 space
        q_nxt.clav_oe  = 1'b1;
        q_nxt.clav_out = tx_fifo_space[0];
      end else if (hit) begin // RULE_07
        q_nxt.clav_oe  = 1'b1;
        q_nxt.clav_out = tx_fifo_space[hit_chan];
      end else begin // RULE_08
        q_nxt.clav_oe  = 1'b0;
        q_nxt.clav_out = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q_r <= '{clk_s1:    1'b0,
               clk_s2:    1'b0,
               clk_s3:    1'b0,
               bus_s1:    tma_pkg::NULL_ADDR,
               bus_s2:    tma_pkg::NULL_ADDR,
               select:    tma_pkg::SELECT_RST,
               chan_addr: {4{tma_pkg::CHAN_ADDR_RST}}, // RULE_01
               ctrl0:     tma_pkg::CTRL0_RST,
               rdata:     tma_pkg::RDATA_IDLE,
               clav_out:  1'b0,
               clav_oe:   1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata             = q_r.rdata;
  assign tx_cell_available_out = q_r.clav_out;
  assign tx_cell_available_oe  = q_r.clav_oe;
  assign multi_phy_mode        = q_r.ctrl0[tma_pkg::MULTI_PHY_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // host write of the channel-select register
  sequence s_sel_wr;
    reg_wr && reg_addr == tma_pkg::OFS_TX_SELECT;
  endsequence

  sequence s_addr_wr;
    reg_wr && reg_addr == tma_pkg::OFS_TX_ADDR && ptr_valid(q_r.select);
  endsequence

  // detected link edge while the shared line is polled per address
  sequence s_poll_edge;
    link_edge && q_r.ctrl0[tma_pkg::MULTI_PHY_BIT];
  endsequence

  a_pointer_moves: assert property ( // RULE_02
    @(posedge core_clk) disable iff (!rstn)
    s_sel_wr |=> q_r.select == $past(reg_wdata[4:0]))
    else $error("pointer did not follow select write");

  a_addr_lands: assert property ( // RULE_03
    @(posedge core_clk) disable iff (!rstn)
    s_addr_wr |=> q_r.chan_addr[$past(q_r.select[1:0])]
                  == $past(reg_wdata[4:0]))
    else $error("address not stored in pointed channel");

  a_others_kept: assert property ( // RULE_10
    @(posedge core_clk) disable iff (!rstn)
    (reg_wr && reg_addr == tma_pkg::OFS_TX_ADDR && q_r.select == 5'h0)
    |=> $stable(q_r.chan_addr[3:1]))
    else $error("write disturbed another channel");

  a_bad_pointer: assert property ( // RULE_01
    @(posedge core_clk) disable iff (!rstn)
    (reg_wr && !ptr_valid(q_r.select) && reg_addr != tma_pkg::OFS_TX_SELECT)
    |=> $stable(q_r.chan_addr))
    else $error("channel table changed with pointer out of range");

  a_mode_bit: assert property ( // RULE_09
    @(posedge core_clk) disable iff (!rstn)
    (reg_wr && reg_addr == tma_pkg::OFS_TX_CTRL0)
    |=> multi_phy_mode == $past(reg_wdata[tma_pkg::MULTI_PHY_BIT]))
    else $error("mode bit did not follow control write");

  a_match_drives: assert property ( // RULE_07
    @(posedge core_clk) disable iff (!rstn)
    (s_poll_edge ##0 hit)
    |=> tx_cell_available_oe
        && tx_cell_available_out == $past(tx_fifo_space[hit_chan]))
    else $error("owned address not answered");

  a_null_quiet: assert property ( // RULE_08
    @(posedge core_clk) disable iff (!rstn)
    (s_poll_edge ##0 q_r.bus_s2 == tma_pkg::NULL_ADDR)
    |=> !tx_cell_available_oe)
    else $error("null address drove cell-available");

  // in multi-phy mode an address owned by no channel leaves the shared line released
  a_unowned_quiet: assert property ( // RULE_07
    @(posedge core_clk) disable iff (!rstn)
    (s_poll_edge ##0 !hit)
    |=> !tx_cell_available_oe && !tx_cell_available_out)
    else $error("unowned address drove cell-available");

  // single-phy mode owns the line and answers for channel 0
  a_single_drives: assert property ( // RULE_09
    @(posedge core_clk) disable iff (!rstn)
    (link_edge && !q_r.ctrl0[tma_pkg::MULTI_PHY_BIT])
    |=> tx_cell_available_oe
        && tx_cell_available_out == $past(tx_fifo_space[0]))
    else $error("single-phy poll not answered from channel 0");

  a_hold_between: assert property ( // RULE_07
    @(posedge core_clk) disable iff (!rstn)
    !link_edge |=> $stable(tx_cell_available_oe)
                   && $stable(tx_cell_available_out))
    else $error("poll answer moved without a link edge");

  // a read a few cycles after pointing shows that channel's address
  a_addr_read: assert property ( // RULE_03
    @(posedge core_clk) disable iff (!rstn)
    (s_sel_wr ##[1:4] (reg_rd && !reg_wr && reg_addr == tma_pkg::OFS_TX_ADDR
                       && ptr_valid(q_r.select)))
    |=> reg_rdata[7:5] == 3'h0
        && reg_rdata[4:0] == $past(q_r.chan_addr[q_r.select[1:0]]))
    else $error("address read does not show pointed channel");

endmodule

`default_nettype wire

// ===== design/tma_pkg.sv
// constants, field layouts and state record of the transmit address bank
// assumes an 8-bit host register port and one core clock of 100 MHz
//
// What this block does
// RULE_01 - hold one transmit address per channel, four
// RULE_02 - channel-select write moves the assignment pointer
// RULE_03 - address write goes to pointed channel
// RULE_04 - host programs unique addresses 0x00 to 0x1e
// RULE_05 - host never programs 0x1f as address
// RULE_06 - transmit assignment leaves receive address untouched
// RULE_07 - sample bus each clock edge, drive on match
// RULE_08 - 0x1f is null, never drives cell-available; in single-phy mode the code drives it for any address
// RULE_09 - control byte 0 bit 6 enables multi-phy
// RULE_10 - other channels keep their assigned addresses
package tma_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned        ADDR_W        = 12;
  localparam logic [11:0]        OFS_TX_CTRL0  = 12'h483; // control byte 0
  localparam logic [11:0]        OFS_TX_ADDR   = 12'h593; // address value
  localparam logic [11:0]        OFS_TX_SELECT = 12'h597; // channel select

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned        FIELD_W       = 5;     // [4:0] fields
  localparam int unsigned        MULTI_PHY_BIT = 6;     // ctrl0 mode bit
  localparam int unsigned        CHAN_NUM      = 4;     // channels
  localparam int unsigned        CHAN_W        = 2;     // channel index
  localparam logic [4:0]         NULL_ADDR     = 5'h1f; // owns no phy
  localparam logic [7:0]         CTRL0_RST     = 8'hcc; // unknowns as 0
  localparam logic [4:0]         SELECT_RST    = 5'h00;
  localparam logic [4:0]         CHAN_ADDR_RST = 5'h1f; // unassigned
  localparam logic [7:0]         RDATA_IDLE    = 8'h00; // unmapped reads

  // ----------------------------------------------------------------
  // whole state of the bank, registered as one record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                        clk_s1;     // link clock, first stage
    logic                        clk_s2;     // link clock, second stage
    logic                        clk_s3;     // previous level, for edge
    logic [4:0]                  bus_s1;     // address bus, first stage
    logic [4:0]                  bus_s2;     // address bus, second stage
    logic [4:0]                  select;     // assignment pointer
    logic [3:0][4:0]             chan_addr;  // per-channel tx address
    logic [7:0]                  ctrl0;      // control byte 0
    logic [7:0]                  rdata;      // read data latch
    logic                        clav_out;   // cell-available level
    logic                        clav_oe;    // cell-available enable
  } tma_state_s;

endpackage

// ===== design/tma_addr_match.sv
// address comparator of the transmit address bank
// assumes a sampled bus address and the four programmed channel addresses
`timescale 1ns/1ps
`default_nettype none

module tma_addr_match (
  input  wire logic [4:0]       bus_addr,   // sampled bus address
  input  wire logic [3:0][4:0]  chan_addr,  // programmed addresses
  output logic                  hit,        // some channel owns it
  output logic [1:0]            chan        // owning channel
);

  // ----------------------------------------------------------------
  // compare against every channel, lowest channel wins a tie
  // ----------------------------------------------------------------
  always_comb begin
    hit  = 1'b0;
    chan = 2'h0;
    // null address never matches, even if wrongly programmed
    if (bus_addr != tma_pkg::NULL_ADDR) begin // RULE_08
      for (int i = tma_pkg::CHAN_NUM - 1; i >= 0; i--) begin
        if (chan_addr[i] == bus_addr) begin // RULE_07
          hit  = 1'b1;
          chan = i[1:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== sim/tma_atm_poller.sv
// far-side model: the cell-layer processor that polls the address bank
// assumes core_clk for pacing; link clock stands still between polls
`timescale 1ns/1ps
`default_nettype none

module tma_atm_poller (
  input  wire logic       core_clk,           // pacing clock
  output var  logic       tx_interface_clock, // link clock, idle low
  output var  logic [4:0] tx_phy_address_bus, // poll address
  input  wire logic       clav_out,           // cell-available level
  input  wire logic       clav_oe             // cell-available enable
);
  wire logic clav_line; // shared line, floats when nobody drives
  assign clav_line = clav_oe ? clav_out : 1'bz;

  initial begin
    tx_interface_clock = 1'b0;
    tx_phy_address_bus = 5'h1f;
  end

  // ------------------------------------------------------------
  // one poll: address first, one link edge, line read a period on
  // ------------------------------------------------------------
  task automatic poll(input logic [4:0] a, output logic seen);
    @(posedge core_clk) tx_phy_address_bus <= a; // stable around edge
    repeat (4) @(posedge core_clk);
    tx_interface_clock <= 1'b1;
    repeat (4) @(posedge core_clk);
    tx_interface_clock <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 seen = clav_line;
  endtask
endmodule

`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench of the transmit address bank
// assumes the poller model on the link side; host port driven here
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        core_clk;  // 100 MHz
  logic        rstn;      // sync reset, low
  logic [11:0] reg_addr;  // host offset
  logic        reg_wr;    // write strobe
  logic        reg_rd;    // read strobe
  logic [7:0]  reg_wdata; // write data
  logic [7:0]  reg_rdata; // read data
  logic [3:0]  space;     // per-channel room
  logic        lclk;      // link clock
  logic [4:0]  lbus;      // poll address
  logic        cl_out;    // clav level
  logic        cl_oe;     // clav enable
  logic        mode;      // multi-phy in use
  logic [4:0]  addrs [4] = '{5'h00, 5'h1e, 5'h0a, 5'h15}; // unique
  int          errors  = 0;
  int          n_tests = 0;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  tma_bank i_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_fifo_space(space),
    .tx_interface_clock(lclk), .tx_phy_address_bus(lbus),
    .tx_cell_available_out(cl_out), .tx_cell_available_oe(cl_oe),
    .multi_phy_mode(mode));

  tma_atm_poller i_atm (.core_clk(core_clk), .tx_interface_clock(lclk),
    .tx_phy_address_bus(lbus), .clav_out(cl_out), .clav_oe(cl_oe));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input string n, input logic [11:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 check(n, reg_rdata, e);
  endtask

  task automatic pchk(input logic [4:0] a, input logic e);
    logic s;
    i_atm.poll(a, s);
    check("clav line", {7'h00, s}, {7'h00, e});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd("ctrl0", 12'h483, tma_pkg::CTRL0_RST);
    rd("select", 12'h597, 8'h00);
    rd("unmapped", 12'h000, 8'h00);
    check("mode", {7'h00, mode}, 8'h01);
  endtask

  task automatic t_assign;
    for (int c = 0; c < 4; c++) begin
      wr(12'h597, 8'he0 | 8'(c));
      wr(12'h593, {3'h7, addrs[c]});
    end
    for (int c = 0; c < 4; c++) begin
      wr(12'h597, 8'(c));
      rd("select", 12'h597, 8'(c));
      rd("chan addr", 12'h593, {3'h0, addrs[c]});
    end
  endtask

  task automatic t_refuse;
    wr(12'h597, 8'h04);
    wr(12'h593, 8'h11);
    rd("select", 12'h597, 8'h04);
    rd("addr none", 12'h593, 8'h00);
    pchk(5'h11, 1'bz);
  endtask

  task automatic t_poll(input logic [3:0] sp);
    @(posedge core_clk) space <= sp;
    for (int c = 0; c < 4; c++) pchk(addrs[c], sp[c]);
    pchk(5'h1f, 1'bz);
    pchk(5'h0b, 1'bz);
  endtask

  task automatic t_single;
    wr(12'h483, 8'h8c);
    #1 check("mode", {7'h00, mode}, 8'h00);
    pchk(5'h1f, space[0]);
    wr(12'h483, 8'hcc);
    pchk(5'h1f, 1'bz);
  endtask

  task automatic print_verdict;
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #50us;
    errors++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    space = 4'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_assign();
    t_refuse();
    t_poll(4'b0101);
    t_poll(4'b1010);
    t_single();
    print_verdict();
  end
endmodule

`default_nettype wire
